//--- rtl/rif_pkg.sv
// rif_pkg: register map, field positions and reset values for the reader irq block
// assumes a single mclk domain; registers sit at byte offsets on a plain port
package rif_pkg;
    localparam int unsigned RIF_AW = 8;
    localparam logic [7:0] RIF_OFF_COMMAND = 8'h01;
    localparam logic [7:0] RIF_OFF_PRI_EN = 8'h02;
    localparam logic [7:0] RIF_OFF_SEC_EN = 8'h03;
    localparam logic [7:0] RIF_OFF_PRI_REQ = 8'h04;
    localparam logic [7:0] RIF_OFF_SEC_REQ = 8'h05;
    localparam logic [7:0] RIF_OFF_OPTIONS = 8'h0C;
    localparam logic [7:0] RIF_OFF_STATUS = 8'h0D;
    // primary request bit positions
    localparam int unsigned RIF_B_SELECTOR = 7;
    localparam int unsigned RIF_B_TX = 6;
    localparam int unsigned RIF_B_RX = 5;
    localparam int unsigned RIF_B_IDLE = 4;
    localparam int unsigned RIF_B_HI = 3;
    localparam int unsigned RIF_B_LO = 2;
    localparam int unsigned RIF_B_ERR = 1;
    localparam int unsigned RIF_B_TIMER = 0;
    // secondary enable and flag positions, primary invert bit and option bit
    localparam int unsigned RIF_B_STYLE = 7;
    localparam int unsigned RIF_B_CARD = 5;
    localparam int unsigned RIF_B_CRC = 2;
    localparam int unsigned RIF_B_INVERT = 7;
    localparam int unsigned RIF_B_RECEIVE_NO_ERROR_OPTION = 0;
    localparam logic [7:0] RIF_SEC_MASK = 8'hA4;
    localparam logic [7:0] RIF_SECREQ_MASK = 8'h24;
    localparam logic [6:0] RIF_PRI_REQ_RST = 7'h14;
    localparam logic [7:0] RIF_PRI_EN_RST = 8'h80;
    localparam logic [7:0] RIF_SEC_EN_RST = 8'h00;
    localparam logic [3:0] RIF_CMD_IDLE = 4'h0;
    localparam logic [15:0] RIF_KNOWN_CMDS = 16'hFFFF;

    typedef enum logic [1:0] {RIF_S_IDLE = 2'b00, RIF_S_RUN = 2'b01, RIF_S_DONE = 2'b11} rif_cmd_state_t;

    // flag update: hardware set wins over a software clear
    function automatic logic [7:0] rif_flag_update(input logic [7:0] cur, input logic [7:0] hw_set,
                                                   input logic wr, input logic [7:0] wdata);
        logic [7:0] res;
        res = cur;
        if (wr) begin
            if (wdata[7]) begin
                res = cur | {1'b0, wdata[6:0]};
            end else begin
                res = cur & ~{1'b0, wdata[6:0]};
            end
        end
        return res | hw_set;
    endfunction
endpackage

//--- rtl/rif_sync_if.sv
// rif_sync_if: synchronised event levels passed from the input stage to the core
// assumes both ends run on mclk
`timescale 1ns/1ps
interface rif_sync_if;
    logic [9:0] ev;
    modport src (output ev);
    modport dst (input ev);
endinterface

//--- rtl/rif_sync.sv
// rif_sync: two-flop synchronisers for event pins arriving from other domains
// assumes events are levels or pulses at least two mclk cycles wide
`timescale 1ns/1ps
module rif_sync
    import rif_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [9:0] ev_async,
    rif_sync_if.src so
);
    logic [9:0] meta_reg;
    logic [9:0] sync_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 10'h000;
            sync_reg <= 10'h000;
        end else if (ce) begin
            meta_reg <= ev_async;
            sync_reg <= meta_reg;
        end
    end
    assign so.ev = sync_reg;
endmodule

//--- rtl/rif_cmd.sv
// rif_cmd: command tracker; flags idle when a command ends or is unknown
// assumes cmd_done comes from same-clock logic
`timescale 1ns/1ps
module rif_cmd
    import rif_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cmd_wr,
    input wire logic [3:0] cmd_code,
    input wire logic cmd_done,
    output logic [3:0] cmd_now,
    output logic idle_pulse
);
    rif_cmd_state_t state_reg, state_next;
    logic [3:0] cmd_reg, cmd_next;
    wire known = RIF_KNOWN_CMDS[cmd_code] && (cmd_code != RIF_CMD_IDLE);
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        unique case (state_reg)
            RIF_S_IDLE: begin
                if (cmd_wr) begin
                    cmd_next = known ? cmd_code : RIF_CMD_IDLE;
                    state_next = known ? RIF_S_RUN : RIF_S_DONE;
                end
            end
            RIF_S_RUN: begin
                if (cmd_done || (cmd_wr && cmd_code == RIF_CMD_IDLE)) begin
                    cmd_next = RIF_CMD_IDLE;
                    state_next = RIF_S_DONE;
                end
            end
            RIF_S_DONE: state_next = RIF_S_IDLE;
            default: state_next = RIF_S_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= RIF_S_IDLE;
            cmd_reg <= RIF_CMD_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
        end
    end
    assign cmd_now = cmd_reg;
    // [RL9] idle on termination
    assign idle_pulse = (state_reg == RIF_S_DONE);
endmodule

//--- rtl/rif_top.sv
// rif_top: interrupt request flags, enables and irq pin of the reader front end
// assumes host port on mclk; error, card and crc pins asynchronous, other events, cmd_done and timer on mclk
//
// Overview of operation
// [RL1] Style bit 1 drives the irq pin push-pull, 0 makes it open-drain.
// [RL2] Card-detect flag reaches the pin only while enable bit 5 is set.
// [RL3] CRC-done flag reaches the pin only while enable bit 2 is set.
// [RL4] Writing the request register with bit 7 high sets every flag written as one.
// [RL5] Writing it with bit 7 low clears every flag written as one.
// [RL6] Every request flag is host-clearable and hardware-settable.
// [RL7] Transmit-done flag bit 6 sets when the last bit of a frame is sent.
// [RL8] Receive flag bit 5 sets on valid received data while the no-error option is on.
// [RL9] Idle flag sets when a command ends; an unknown command reads back zero and sets it.
// [RL10] The pin asserts whenever any enabled flag is set.
// [RL11] Error flag sets whenever any error status bit becomes set.
// [RL12] Timer flag sets when the down-counting timer reaches zero.
// [RL13] Pin level follows the request state, inverted when invert bit is 1; it resets to 1.
`timescale 1ns/1ps
module rif_top
    import rif_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic tx_last_bit,
    input wire logic rx_data_valid,
    input wire logic fifo_high_alert,
    input wire logic fifo_low_alert,
    input wire logic card_detected,
    input wire logic crc_checked,
    input wire logic [7:0] error_status,
    input wire logic cmd_done,
    input wire logic [15:0] timer_count_value,
    output logic irq_out,
    output logic irq_oe_b
);
    ////////////////////////////////////////////////////////////////
    rif_sync_if sx();
    rif_sync u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .ev_async({error_status, card_detected, crc_checked}),
        .so(sx)
    );
    wire logic card_s = sx.ev[1];
    wire logic crc_s = sx.ev[0];
    wire logic [7:0] err_s = sx.ev[9:2];

    logic [3:0] cmd_now;
    logic idle_pulse;
    wire logic wr_cmd = wr && (addr == RIF_OFF_COMMAND);
    rif_cmd u_cmd (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .cmd_wr(wr_cmd),
        .cmd_code(wdata[3:0]),
        .cmd_done(cmd_done),
        .cmd_now(cmd_now),
        .idle_pulse(idle_pulse)
    );

    ////////////////////////////////////////////////////////////////
    logic [7:0] pri_en_reg;
    logic [7:0] sec_en_reg;
    logic [7:0] pri_req_reg, pri_req_next;
    logic [7:0] sec_req_reg, sec_req_next;
    logic [7:0] opt_reg;
    logic [7:0] err_prev_reg;
    logic [15:0] tval_prev_reg;
    logic [7:0] rdata_reg;
    logic irq_out_reg;
    logic irq_oe_b_reg;

    wire logic wr_pri_en = wr && (addr == RIF_OFF_PRI_EN);
    wire logic wr_sec_en = wr && (addr == RIF_OFF_SEC_EN);
    wire logic wr_pri_req = wr && (addr == RIF_OFF_PRI_REQ);
    wire logic wr_sec_req = wr && (addr == RIF_OFF_SEC_REQ);
    wire logic wr_opt = wr && (addr == RIF_OFF_OPTIONS);

    // [RL11] rising error bits
    wire logic err_rise = |(err_s & ~err_prev_reg);
    // [RL12] count arrives at zero
    wire logic timer_zero = (timer_count_value == 16'h0000) && (tval_prev_reg != 16'h0000);
    // [RL8] receive gated by option
    wire logic rx_set = rx_data_valid && opt_reg[RIF_B_RECEIVE_NO_ERROR_OPTION];

    logic [7:0] pri_hw;
    always_comb begin
        pri_hw = 8'h00;
        // [RL7] last bit of frame
        pri_hw[RIF_B_TX] = tx_last_bit;
        pri_hw[RIF_B_RX] = rx_set;
        pri_hw[RIF_B_IDLE] = idle_pulse;
        pri_hw[RIF_B_HI] = fifo_high_alert;
        pri_hw[RIF_B_LO] = fifo_low_alert;
        pri_hw[RIF_B_ERR] = err_rise;
        pri_hw[RIF_B_TIMER] = timer_zero;
    end
    wire logic [7:0] sec_hw = {2'b00, card_s, 2'b00, crc_s, 2'b00};

    // [RL4] [RL5] [RL6] selector set or clear
    assign pri_req_next = rif_flag_update(pri_req_reg, pri_hw, wr_pri_req, wdata);
    assign sec_req_next = rif_flag_update(sec_req_reg, sec_hw, wr_sec_req, wdata) & RIF_SECREQ_MASK;

    // [RL2] [RL3] [RL10] enabled requests
    wire logic pri_any = |(pri_req_reg[6:0] & pri_en_reg[6:0]);
    wire logic card_fwd = sec_req_reg[RIF_B_CARD] && sec_en_reg[RIF_B_CARD];
    wire logic crc_fwd = sec_req_reg[RIF_B_CRC] && sec_en_reg[RIF_B_CRC];
    wire logic req_any = pri_any || card_fwd || crc_fwd;
    // [RL13] polarity
    wire logic pin_level = req_any ^ pri_en_reg[RIF_B_INVERT];
    // [RL1] open-drain releases on high
    wire logic oe_b_next = sec_en_reg[RIF_B_STYLE] ? 1'b0 : pin_level;

    wire logic [7:0] rd_mux =
        (addr == RIF_OFF_COMMAND) ? {4'h0, cmd_now} :
        (addr == RIF_OFF_PRI_EN) ? pri_en_reg :
        (addr == RIF_OFF_SEC_EN) ? sec_en_reg :
        (addr == RIF_OFF_PRI_REQ) ? {1'b0, pri_req_reg[6:0]} :
        (addr == RIF_OFF_SEC_REQ) ? sec_req_reg :
        (addr == RIF_OFF_OPTIONS) ? opt_reg :
        (addr == RIF_OFF_STATUS) ? {7'h00, req_any} : 8'h00;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pri_en_reg <= RIF_PRI_EN_RST;
            sec_en_reg <= RIF_SEC_EN_RST;
            opt_reg <= 8'h00;
        end else if (ce) begin
            if (wr_pri_en) begin
                pri_en_reg <= wdata;
            end
            if (wr_sec_en) begin
                sec_en_reg <= wdata & RIF_SEC_MASK;
            end
            if (wr_opt) begin
                opt_reg <= {7'h00, wdata[RIF_B_RECEIVE_NO_ERROR_OPTION]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pri_req_reg <= {1'b0, RIF_PRI_REQ_RST};
            sec_req_reg <= 8'h00;
            err_prev_reg <= 8'h00;
            tval_prev_reg <= 16'h0000;
        end else if (ce) begin
            pri_req_reg <= {1'b0, pri_req_next[6:0]};
            sec_req_reg <= sec_req_next;
            err_prev_reg <= err_s;
            tval_prev_reg <= timer_count_value;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
            irq_out_reg <= 1'b1;
            // released, so an open-drain pin never drives high
            irq_oe_b_reg <= 1'b1;
        end else if (ce) begin
            rdata_reg <= rd ? rd_mux : 8'h00;
            irq_out_reg <= pin_level;
            irq_oe_b_reg <= oe_b_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq_out = irq_out_reg;
    assign irq_oe_b = irq_oe_b_reg;

    ////////////////////////////////////////////////////////////////
    property p_style;
        @(posedge mclk) disable iff (!rst_b)
        ce && sec_en_reg[RIF_B_STYLE] |=> !irq_oe_b;
    endproperty
    a_style: assert property (p_style) else $error("push-pull pin not driven"); // [RL1]

    property p_card;
        @(posedge mclk) disable iff (!rst_b)
        ce && !sec_en_reg[RIF_B_CARD] && !pri_any && !crc_fwd |=> irq_out == $past(pri_en_reg[RIF_B_INVERT]);
    endproperty
    a_card: assert property (p_card) else $error("card flag leaked to pin"); // [RL2]

    property p_crc;
        @(posedge mclk) disable iff (!rst_b)
        ce && crc_fwd |=> irq_out != $past(pri_en_reg[RIF_B_INVERT]);
    endproperty
    a_crc: assert property (p_crc) else $error("enabled crc flag not on pin"); // [RL3]

    property p_set;
        @(posedge mclk) disable iff (!rst_b)
        ce && wr_pri_req && wdata[7] |=> ((pri_req_reg[6:0] & $past(wdata[6:0])) == $past(wdata[6:0]));
    endproperty
    a_set: assert property (p_set) else $error("selector set failed"); // [RL4]

    property p_clr;
        @(posedge mclk) disable iff (!rst_b)
        ce && wr_pri_req && !wdata[7] && !(|pri_hw) |=> ((pri_req_reg[6:0] & $past(wdata[6:0])) == 7'h00);
    endproperty
    a_clr: assert property (p_clr) else $error("selector clear failed"); // [RL5]

    property p_tx;
        @(posedge mclk) disable iff (!rst_b)
        ce && tx_last_bit |=> pri_req_reg[RIF_B_TX];
    endproperty
    a_tx: assert property (p_tx) else $error("tx flag not set"); // [RL7]

    wire logic known_cmd = RIF_KNOWN_CMDS[wdata[3:0]] && (wdata[3:0] != RIF_CMD_IDLE);
    wire logic state_idle = (u_cmd.state_reg == RIF_S_IDLE);
    sequence s_unknown;
        ce && wr_cmd && !known_cmd && state_idle;
    endsequence
    property p_idle;
        @(posedge mclk) disable iff (!rst_b)
        s_unknown ##1 ce |=> pri_req_reg[RIF_B_IDLE] && cmd_now == RIF_CMD_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("unknown command not idled"); // [RL9]

    property p_timer;
        @(posedge mclk) disable iff (!rst_b)
        ce && timer_zero |=> pri_req_reg[RIF_B_TIMER];
    endproperty
    a_timer: assert property (p_timer) else $error("timer flag not set"); // [RL12]

    property p_pol;
        @(posedge mclk) disable iff (!rst_b)
        ce |=> irq_out == ($past(req_any) ^ $past(pri_en_reg[RIF_B_INVERT]));
    endproperty
    a_pol: assert property (p_pol) else $error("pin polarity wrong"); // [RL13]

    property p_od;
        @(posedge mclk) disable iff (!rst_b)
        ce && !sec_en_reg[RIF_B_STYLE] |=> irq_oe_b == irq_out;
    endproperty
    a_od: assert property (p_od) else $error("open-drain pin driven high"); // [RL1]

    property p_card_fwd;
        @(posedge mclk) disable iff (!rst_b)
        ce && card_fwd |=> irq_out != $past(pri_en_reg[RIF_B_INVERT]);
    endproperty
    a_card_fwd: assert property (p_card_fwd) else $error("enabled card flag not on pin"); // [RL2]

    property p_sec_set;
        @(posedge mclk) disable iff (!rst_b)
        ce && wr_sec_req && wdata[7] |=> ((sec_req_reg & $past(wdata) & RIF_SECREQ_MASK) == ($past(wdata) & RIF_SECREQ_MASK));
    endproperty
    a_sec_set: assert property (p_sec_set) else $error("secondary selector set failed"); // [RL4]

    property p_sec_clr;
        @(posedge mclk) disable iff (!rst_b)
        ce && wr_sec_req && !wdata[7] && !(|sec_hw) |=> ((sec_req_reg & $past(wdata) & RIF_SECREQ_MASK) == 8'h00);
    endproperty
    a_sec_clr: assert property (p_sec_clr) else $error("secondary selector clear failed"); // [RL5]

    property p_hw_wins;
        @(posedge mclk) disable iff (!rst_b)
        ce && wr_pri_req && !wdata[RIF_B_SELECTOR] && (|pri_hw)
            |=> ((pri_req_reg[6:0] & $past(pri_hw[6:0])) == $past(pri_hw[6:0]));
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("clear beat a hardware set"); // [RL6]

    property p_tx_hold;
        @(posedge mclk) disable iff (!rst_b)
        ce && pri_req_reg[RIF_B_TX] && !wr_pri_req |=> pri_req_reg[RIF_B_TX];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("flag dropped without a write"); // [RL6]

    property p_rx;
        @(posedge mclk) disable iff (!rst_b)
        ce && rx_set |=> pri_req_reg[RIF_B_RX];
    endproperty
    a_rx: assert property (p_rx) else $error("rx flag not set"); // [RL8]

    property p_rx_gate;
        @(posedge mclk) disable iff (!rst_b)
        ce && !opt_reg[RIF_B_RECEIVE_NO_ERROR_OPTION] && !pri_req_reg[RIF_B_RX]
            && !(wr_pri_req && wdata[RIF_B_SELECTOR] && wdata[RIF_B_RX]) |=> !pri_req_reg[RIF_B_RX];
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx flag set with option off"); // [RL8]

    sequence s_cmd_end;
        ce && cmd_done && (cmd_now != RIF_CMD_IDLE);
    endsequence
    property p_done;
        @(posedge mclk) disable iff (!rst_b)
        s_cmd_end ##1 ce |=> pri_req_reg[RIF_B_IDLE];
    endproperty
    a_done: assert property (p_done) else $error("ended command not idled"); // [RL9]

    property p_status;
        @(posedge mclk) disable iff (!rst_b)
        ce && rd && (addr == RIF_OFF_STATUS) |=> rdata == {7'h00, $past(req_any)};
    endproperty
    a_status: assert property (p_status) else $error("combined request misread"); // [RL10]

    property p_err;
        @(posedge mclk) disable iff (!rst_b)
        ce && err_rise |=> pri_req_reg[RIF_B_ERR];
    endproperty
    a_err: assert property (p_err) else $error("error flag not set"); // [RL11]
endmodule

//--- dv/rif_host_model.sv
// rif_host_model: host side of the irq block, register port master and irq pin
// assumes strobes launch right after a rising mclk edge; the pin has a pull-up
`timescale 1ns/1ps
module rif_host_model
    import rif_pkg::*;
(
    input wire logic mclk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq_out,
    input wire logic irq_oe_b,
    output logic irq_pin
);
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // pin resolution
    // released pin floats to the pull-up, never the last driven level
    assign irq_pin = irq_oe_b ? 1'b1 : irq_out;
    ////////////////////////////////////////////////////////////////
    // host register writes and reads
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        // stale data flips so it is never taken for a new write
        wdata <= ~d;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule

//--- dv/test_reader_irq_flags_and_enables.sv
// test_reader_irq_flags_and_enables: self-checking bench of rif_top
// assumes rif_host_model drives the register port and resolves the pin
`timescale 1ns/1ps
module test_reader_irq_flags_and_enables
    import rif_pkg::*;
;
    logic mclk, rst_b, ce, wr, rd, irq_out, irq_oe_b, irq_pin;
    logic [7:0] addr, wdata, rdata, error_status, pen, sen, sec, rv;
    logic tx_last_bit, rx_data_valid, fifo_high_alert, fifo_low_alert;
    logic card_detected, crc_checked, cmd_done, rx_on;
    logic [15:0] timer_count_value;
    logic [6:0] pri;
    logic [31:0] seed;
    int miscompares, n_checks;

    rif_top uut(.mclk(mclk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_last_bit(tx_last_bit), .rx_data_valid(rx_data_valid),
        .fifo_high_alert(fifo_high_alert), .fifo_low_alert(fifo_low_alert),
        .card_detected(card_detected), .crc_checked(crc_checked), .error_status(error_status),
        .cmd_done(cmd_done), .timer_count_value(timer_count_value), .irq_out(irq_out),
        .irq_oe_b(irq_oe_b));
    rif_host_model uhost(.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq_out(irq_out), .irq_oe_b(irq_oe_b), .irq_pin(irq_pin));

    always #2.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000C5 : 32'h00000000);
    endfunction
    function automatic logic f_irq();
        return (|(pri & pen[6:0]) | |(sec & sen & RIF_SECREQ_MASK)) ^ pen[RIF_B_INVERT];
    endfunction
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        uhost.bus_rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic pin_chk();
        logic e;
        repeat (2) @(posedge mclk);
        #1;
        e = f_irq();
        chk({7'h00, irq_out}, {7'h00, e});
        chk({7'h00, irq_oe_b}, {7'h00, e & ~sen[RIF_B_STYLE]});
        chk({7'h00, irq_pin}, {7'h00, e});
    endtask
    // async sources held four cycles to clear the synchronisers
    task automatic ev(input int i);
        @(posedge mclk);
        case (i)
            0: tx_last_bit <= 1'b1;
            1: rx_data_valid <= 1'b1;
            2: fifo_high_alert <= 1'b1;
            3: fifo_low_alert <= 1'b1;
            4: error_status <= 8'h01 << seed[2:0];
            5: timer_count_value <= 16'h0000;
            6: cmd_done <= 1'b1;
            7: card_detected <= 1'b1;
            default: crc_checked <= 1'b1;
        endcase
        case (i)
            0: pri[RIF_B_TX] = 1'b1;
            1: pri[RIF_B_RX] = rx_on | pri[RIF_B_RX];
            2: pri[RIF_B_HI] = 1'b1;
            3: pri[RIF_B_LO] = 1'b1;
            4: pri[RIF_B_ERR] = 1'b1;
            5: pri[RIF_B_TIMER] = 1'b1;
            6: pri[RIF_B_IDLE] = 1'b1;
            7: sec[RIF_B_CARD] = 1'b1;
            default: sec[RIF_B_CRC] = 1'b1;
        endcase
        @(posedge mclk);
        {tx_last_bit, rx_data_valid, fifo_high_alert, fifo_low_alert, cmd_done} <= 5'h00;
        repeat (3) @(posedge mclk);
        {card_detected, crc_checked} <= 2'b00;
        error_status <= 8'h00;
        timer_count_value <= 16'h0001;
        repeat (6) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        results();
    end
    initial begin
        {mclk, rst_b, tx_last_bit, rx_data_valid, fifo_high_alert, fifo_low_alert} = 6'h00;
        {card_detected, crc_checked, cmd_done, rx_on} = 4'h0;
        ce = 1'b1;
        error_status = 8'h00;
        timer_count_value = 16'h0001;
        seed = 32'h77DF9C3E;
        repeat (20) @(posedge mclk);
        chk({6'h00, irq_out, irq_oe_b}, 8'h03);
        rst_b <= 1'b1;
        pri = RIF_PRI_REQ_RST;
        pen = RIF_PRI_EN_RST;
        sen = RIF_SEC_EN_RST;
        sec = 8'h00;
        rd_chk(RIF_OFF_PRI_EN, 8'h80);
        rd_chk(RIF_OFF_SEC_EN, 8'h00);
        rd_chk(RIF_OFF_PRI_REQ, 8'h14);
        rd_chk(8'h7F, 8'h00);
        pin_chk();
        for (int j = 0; j < 2; j++) begin
            rx_on = j[0];
            uhost.bus_wr(RIF_OFF_OPTIONS, {7'h00, rx_on});
            for (int i = 0; i < 9; i++) begin
                uhost.bus_wr(RIF_OFF_PRI_REQ, 8'h7F);
                uhost.bus_wr(RIF_OFF_SEC_REQ, 8'h24);
                pri = 7'h00;
                sec = 8'h00;
                seed = lfsr(seed);
                pen = seed[7:0];
                sen = seed[15:8] & RIF_SEC_MASK;
                uhost.bus_wr(RIF_OFF_PRI_EN, pen);
                uhost.bus_wr(RIF_OFF_SEC_EN, seed[15:8]);
                rd_chk(RIF_OFF_SEC_EN, sen);
                if (i == 6) begin
                    uhost.bus_wr(RIF_OFF_COMMAND, 8'h03);
                    rd_chk(RIF_OFF_COMMAND, 8'h03);
                end
                ev(i);
                rd_chk(RIF_OFF_PRI_REQ, {1'b0, pri});
                rd_chk(RIF_OFF_SEC_REQ, sec);
                pin_chk();
            end
        end
        // unknown command code reads back zero and idles
        uhost.bus_wr(RIF_OFF_COMMAND, 8'h00);
        pri[RIF_B_IDLE] = 1'b1;
        rd_chk(RIF_OFF_COMMAND, 8'h00);
        rd_chk(RIF_OFF_PRI_REQ, {1'b0, pri});
        // hardware set meets a clear in the same cycle
        fork
            uhost.bus_wr(RIF_OFF_PRI_REQ, 8'h08);
            begin
                @(posedge mclk);
                fifo_high_alert <= 1'b1;
                @(posedge mclk);
                fifo_high_alert <= 1'b0;
            end
        join
        pri[RIF_B_HI] = 1'b1;
        rd_chk(RIF_OFF_PRI_REQ, {1'b0, pri});
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            pen = seed[31:24];
            sen = seed[23:16] & RIF_SEC_MASK;
            uhost.bus_wr(RIF_OFF_PRI_EN, pen);
            uhost.bus_wr(RIF_OFF_SEC_EN, seed[23:16]);
            uhost.bus_wr(RIF_OFF_PRI_REQ, {1'b1, seed[6:0]});
            uhost.bus_wr(RIF_OFF_SEC_REQ, {1'b1, seed[14:8]});
            pri = pri | seed[6:0];
            sec = sec | ({1'b0, seed[14:8]} & RIF_SECREQ_MASK);
            rd_chk(RIF_OFF_PRI_REQ, {1'b0, pri});
            pin_chk();
            rd_chk(RIF_OFF_STATUS, {7'h00, f_irq() ^ pen[RIF_B_INVERT]});
            seed = lfsr(seed);
            uhost.bus_wr(RIF_OFF_PRI_REQ, {1'b0, seed[6:0]});
            uhost.bus_wr(RIF_OFF_SEC_REQ, {1'b0, seed[14:8]});
            pri = pri & ~seed[6:0];
            sec = sec & ~({1'b0, seed[14:8]} & RIF_SECREQ_MASK);
            rd_chk(RIF_OFF_PRI_REQ, {1'b0, pri});
            rd_chk(RIF_OFF_SEC_REQ, sec);
            pin_chk();
        end
        // a held clock enable must swallow the write
        ce <= 1'b0;
        uhost.bus_wr(RIF_OFF_PRI_EN, ~pen);
        @(posedge mclk);
        ce <= 1'b1;
        rd_chk(RIF_OFF_PRI_EN, pen);
        results();
    end
endmodule
